// ===== chan_diag_chk.sv
// Purpose: Port assertions for the fault diagnosis block.
// Assumes: One clock domain.  Notes: Bound from the test top.
`timescale 1ns/100ps
module chan_diag_chk(input wire CLOCK_IN, input wire SRST_IN,
    input wire [7:0] OVERLOAD_IN, OVERTEMP_IN, OPEN_LOAD_COND_IN, CHAN_ON_OUT,
    input wire FRAME_VALID_IN, WR_STB_IN, RD_STB_IN, BANK_SEL_IN, CLR_PROT_WR_IN,
    input wire [2:0] ADDR_IN, input wire [3:0] WDATA_IN, input wire CLEAR_PROT_LATCH_OUT,
    input wire [7:0] DIAG_CUR_EN_OUT, PROT_FLAG_OUT, OPEN_LOAD_OUT);
    wire [7:0] ovl_hit = OVERLOAD_IN & CHAN_ON_OUT;
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (SRST_IN);
    sequence frame_only; FRAME_VALID_IN && !CLR_PROT_WR_IN; endsequence
    AST_OVL: assert property (ovl_hit != 8'h00 |=>
        (PROT_FLAG_OUT & $past(ovl_hit)) == $past(ovl_hit)) else $error("overload flag");
    AST_OFF: assert property (!CLR_PROT_WR_IN |=>
        (CHAN_ON_OUT & $past(PROT_FLAG_OUT | OVERTEMP_IN | ovl_hit)) == 8'h00)
        else $error("channel not off");
    AST_OT: assert property (OVERTEMP_IN != 8'h00 |=>
        (PROT_FLAG_OUT & $past(OVERTEMP_IN)) == $past(OVERTEMP_IN)) else $error("temp flag");
    AST_HOLD: assert property (!CLR_PROT_WR_IN |=>
        (PROT_FLAG_OUT | ~$past(PROT_FLAG_OUT)) == 8'hFF) else $error("flag lost");
    AST_CPL: assert property (CLR_PROT_WR_IN |=> CLEAR_PROT_LATCH_OUT)
        else $error("clear bit not set");
    AST_CPL_FRM: assert property (CLEAR_PROT_LATCH_OUT ##0 frame_only |=>
        !CLEAR_PROT_LATCH_OUT) else $error("clear bit stuck");
    AST_OL_ON: assert property ((OPEN_LOAD_OUT & ~$past(OPEN_LOAD_OUT) &
        $past(CHAN_ON_OUT) & $past(CHAN_ON_OUT, 2)) == 8'h00) else $error("open load when on");
    AST_OL_RD: assert property (RD_STB_IN && BANK_SEL_IN &&
        (OPEN_LOAD_COND_IN | $past(OPEN_LOAD_COND_IN)) == 8'h00 |=>
        OPEN_LOAD_OUT[{$past(ADDR_IN[1:0]), 1'h0} +: 2] == 2'h0) else $error("read no clear");
    AST_DCC: assert property (WR_STB_IN && !BANK_SEL_IN && ADDR_IN[2:1] == 2'h2 |=>
        DIAG_CUR_EN_OUT[{$past(ADDR_IN[0]), 2'h0} +: 4] == $past(WDATA_IN))
        else $error("enable write");
endmodule // chan_diag_chk

// ===== chan_diag_regs.vh
// Purpose: Constants for the channel fault diagnosis block.
// Assumes: 200 MHz core clock, 5 ns period.
// Notes:   Times are kept in nanoseconds; cycle counts derive from them.
`ifndef CHAN_DIAG_REGS_VH
`define CHAN_DIAG_REGS_VH
`define CLK_PERIOD_NS          5
`define OPEN_LOAD_DELAY_MIN_NS 100000
`define OPEN_LOAD_DELAY_MAX_NS 250000
`define OPEN_LOAD_DELAY_CYC    ((`OPEN_LOAD_DELAY_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OVERLOAD_SHUTOFF_MAX_NS 60000
`define OVERLOAD_SHUTOFF_CYC   (`OVERLOAD_SHUTOFF_MAX_NS / `CLK_PERIOD_NS)
`define REG_BANK_DIAG          1'h1
`define ADDR_DCC0              3'h4
`define ADDR_DCC1              3'h5
`define DIAG_PROT_LO_BIT       0
`define DIAG_OL_LO_BIT         1
`define DIAG_PROT_HI_BIT       2
`define DIAG_OL_HI_BIT         3
`define DCC_RESET              4'h0
`endif

// ===== channel_fault_diagnosis.v
// Purpose: Protection and open-load latching with channel shutoff for eight channels.
// Assumes: Frame, write and read strobes come from the serial front end as one-cycle pulses.
// Notes:   Overload shutoff happens one cycle after detection, well inside the limit.
// Function
// - A protection flag set by a shutdown holds until the host writes the clear bit.
// - The clear bit returns to zero on the next valid frame after it was written.
// - Open-load detections latch per channel and clear when their diagnosis register is read.
// - No open-load diagnosis is done for a channel that is switched on.
// - An off channel sets its open-load flag after the condition persists for the delay.
// - A written diagnosis current enable bit drives that channel's current enable.
// - Over-temperature sets the protection flag and forces an active channel off.
// - Overload switches the channel off within the shutoff limit and sets its flag.
// - A protected channel stays off regardless of input selection until cleared.
// - Over-temperature sets the protection flag even while the channel is off.
// - Diagnosis registers in bank one hold two channels each, protection at 0 and 2.
// - Current enables live in two 4-bit registers at addresses 100 and 101.
`timescale 1ns/100ps
`include "chan_diag_regs.vh"
module channel_fault_diagnosis #(
    parameter integer OL_DELAY = `OPEN_LOAD_DELAY_CYC
) (
    input  wire       CLOCK_IN,
    input  wire       SRST_IN,
    input  wire [7:0] CHAN_REQ_IN,
    input  wire [7:0] OVERLOAD_IN,
    input  wire [7:0] OVERTEMP_IN,
    input  wire [7:0] OPEN_LOAD_COND_IN,
    input  wire       FRAME_VALID_IN,
    input  wire       WR_STB_IN,
    input  wire       RD_STB_IN,
    input  wire       BANK_SEL_IN,
    input  wire [2:0] ADDR_IN,
    input  wire [3:0] WDATA_IN,
    input  wire       CLR_PROT_WR_IN,
    output reg  [7:0] CHAN_ON_OUT,
    output reg  [7:0] DIAG_CUR_EN_OUT,
    output reg  [7:0] PROT_FLAG_OUT,
    output reg  [7:0] OPEN_LOAD_OUT,
    output reg  [3:0] RDATA_OUT,
    output reg        CLEAR_PROT_LATCH_OUT
);
    localparam integer NCH = 8;

    wire [7:0] ol_done;
    reg  [7:0] ol_clr;
    reg  [7:0] prot_next;
    reg  [7:0] ol_next;
    reg  [7:0] chan_on_next;
    reg  [7:0] dcc_next;
    reg  [3:0] rdata_next;
    reg        cpl_next;
    reg        diag_rd;
    reg        dcc_lo_wr;
    reg        dcc_hi_wr;
    integer    i;
    integer    k;

    // One persistence timer per channel, armed only while the channel is off.
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_ol
            open_load_timer #(
                .DELAY (OL_DELAY),
                .W     (16)
            ) open_load_timer_i (
                .clk_in   (CLOCK_IN),
                .srst_in  (SRST_IN),
                .arm_in   (~CHAN_ON_OUT[g]),
                .cond_in  (OPEN_LOAD_COND_IN[g]),
                .done_out (ol_done[g])
            );
        end
    endgenerate

    // Packs the flags of two channels into one diagnosis register word.
    function [3:0] diag_word;
        input [1:0] pf;
        input [1:0] ol;
        begin
            diag_word                    = 4'h0;
            diag_word[`DIAG_PROT_LO_BIT] = pf[0];
            diag_word[`DIAG_OL_LO_BIT]   = ol[0];
            diag_word[`DIAG_PROT_HI_BIT] = pf[1];
            diag_word[`DIAG_OL_HI_BIT]   = ol[1];
        end
    endfunction

    // Tells whether bank and address select the given current enable register.
    function dcc_match;
        input       bank;
        input [2:0] addr;
        input [2:0] target;
        begin
            dcc_match = (bank != `REG_BANK_DIAG) && (addr == target);
        end
    endfunction

    always @* begin
        diag_rd   = RD_STB_IN && (BANK_SEL_IN == `REG_BANK_DIAG);
        dcc_lo_wr = WR_STB_IN && dcc_match(BANK_SEL_IN, ADDR_IN, `ADDR_DCC0);
        dcc_hi_wr = WR_STB_IN && dcc_match(BANK_SEL_IN, ADDR_IN, `ADDR_DCC1);
    end

    // A diagnosis read clears the open-load flags of the pair it returns.
    always @* begin
        ol_clr = 8'h00;
        if (diag_rd) begin
            case (ADDR_IN[1:0])
                2'h0:    ol_clr = 8'h03;
                2'h1:    ol_clr = 8'h0C;
                2'h2:    ol_clr = 8'h30;
                default: ol_clr = 8'hC0;
            endcase
        end
    end

    // A clear write in the same frame keeps the bit set.
    always @* begin
        cpl_next = CLEAR_PROT_LATCH_OUT;
        if (CLR_PROT_WR_IN) begin
            cpl_next = 1'h1;
        end else if (FRAME_VALID_IN) begin
            cpl_next = 1'h0;
        end
    end

    // A fault in the clearing cycle wins over the clear.
    always @* begin
        for (i = 0; i < NCH; i = i + 1) begin
            prot_next[i] = (PROT_FLAG_OUT[i] && !CLR_PROT_WR_IN)
                || OVERTEMP_IN[i]
                || (OVERLOAD_IN[i] && CHAN_ON_OUT[i]);
        end
    end

    always @* begin
        for (k = 0; k < NCH; k = k + 1) begin
            ol_next[k] = (OPEN_LOAD_OUT[k] && !ol_clr[k]) || ol_done[k];
        end
    end

    always @* begin
        chan_on_next = CHAN_REQ_IN & ~prot_next;
    end

    always @* begin
        dcc_next = DIAG_CUR_EN_OUT;
        if (dcc_lo_wr) begin
            dcc_next[3:0] = WDATA_IN;
        end
        if (dcc_hi_wr) begin
            dcc_next[7:4] = WDATA_IN;
        end
    end

    // Read data follows the selected register one cycle later.
    always @* begin
        rdata_next = 4'h0;
        if (BANK_SEL_IN == `REG_BANK_DIAG) begin
            case (ADDR_IN[1:0])
                2'h0:    rdata_next = diag_word(PROT_FLAG_OUT[1:0], OPEN_LOAD_OUT[1:0]);
                2'h1:    rdata_next = diag_word(PROT_FLAG_OUT[3:2], OPEN_LOAD_OUT[3:2]);
                2'h2:    rdata_next = diag_word(PROT_FLAG_OUT[5:4], OPEN_LOAD_OUT[5:4]);
                default: rdata_next = diag_word(PROT_FLAG_OUT[7:6], OPEN_LOAD_OUT[7:6]);
            endcase
        end else if (dcc_match(BANK_SEL_IN, ADDR_IN, `ADDR_DCC0)) begin
            rdata_next = DIAG_CUR_EN_OUT[3:0];
        end else if (dcc_match(BANK_SEL_IN, ADDR_IN, `ADDR_DCC1)) begin
            rdata_next = DIAG_CUR_EN_OUT[7:4];
        end
    end

    always @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            PROT_FLAG_OUT <= 8'h00;
        end else begin
            PROT_FLAG_OUT <= prot_next;
        end
    end

    always @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            OPEN_LOAD_OUT <= 8'h00;
        end else begin
            OPEN_LOAD_OUT <= ol_next;
        end
    end

    always @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            CHAN_ON_OUT <= 8'h00;
        end else begin
            CHAN_ON_OUT <= chan_on_next;
        end
    end

    always @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            DIAG_CUR_EN_OUT <= {`DCC_RESET, `DCC_RESET};
        end else begin
            DIAG_CUR_EN_OUT <= dcc_next;
        end
    end

    always @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            RDATA_OUT <= 4'h0;
        end else begin
            RDATA_OUT <= rdata_next;
        end
    end

    always @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            CLEAR_PROT_LATCH_OUT <= 1'h0;
        end else begin
            CLEAR_PROT_LATCH_OUT <= cpl_next;
        end
    end
endmodule // channel_fault_diagnosis

// ===== channel_fault_diagnosis_test.sv
// Purpose: Self-checking test of the fault diagnosis block.
// Assumes: Open-load delay of 8 cycles.  Notes: Reads are checked from a queue.
`timescale 1ns/100ps
module channel_fault_diagnosis_test;
    reg CLOCK_IN = 1'h0, SRST_IN = 1'h1, seen = 1'h0;
    reg [7:0] req = 8'hDF, ovl = 8'h00, ot = 8'h00, olc = 8'h00;
    reg [31:0] r;
    reg [3:0] exp_q[$];
    wire fr, wr, rd, cl, bk, clear_protection_latch;
    wire [2:0] ad;
    wire [3:0] wd, rdat;
    wire [7:0] on, dce, pf, olf;
    integer fails = 0, total_checks = 0;
    host_model host_model_i(.clock_in(CLOCK_IN), .fr_out(fr), .wr_out(wr), .rd_out(rd),
        .cl_out(cl), .bk_out(bk), .ad_out(ad), .wd_out(wd));
    channel_fault_diagnosis #(.OL_DELAY(8)) channel_fault_diagnosis_i(.CLOCK_IN(CLOCK_IN),
        .SRST_IN(SRST_IN), .CHAN_REQ_IN(req), .OVERLOAD_IN(ovl), .OVERTEMP_IN(ot),
        .OPEN_LOAD_COND_IN(olc), .FRAME_VALID_IN(fr), .WR_STB_IN(wr), .RD_STB_IN(rd),
        .BANK_SEL_IN(bk), .ADDR_IN(ad), .WDATA_IN(wd), .CLR_PROT_WR_IN(cl),
        .CHAN_ON_OUT(on), .DIAG_CUR_EN_OUT(dce), .PROT_FLAG_OUT(pf), .OPEN_LOAD_OUT(olf),
        .RDATA_OUT(rdat), .CLEAR_PROT_LATCH_OUT(clear_protection_latch));
    initial forever #2.5 CLOCK_IN = ~CLOCK_IN;
    task cmp(input [7:0] a, input [7:0] e);
        begin
            total_checks = total_checks + 1;
            if (a !== e) begin
                fails = fails + 1;
                $display("wrong value at %0t: got %h want %h", $time, a, e);
            end
        end
    endtask
    task rdx(input [1:0] a, input [3:0] e);
        begin
            exp_q.push_back(e);
            host_model_i.op(4'hA, 1'h1, {1'h0, a}, 4'h0);
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", total_checks, fails);
            if (fails == 0 && total_checks > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    always @(posedge CLOCK_IN) seen <= rd;
    always @(negedge CLOCK_IN) if (seen) cmp({4'h0, rdat}, {4'h0, exp_q.pop_front()});
    initial begin
        #20000 fails = fails + 1;
        test_done;
    end
    initial begin
        r = $urandom(57079);
        r = $urandom;
        repeat (3) @(negedge CLOCK_IN);
        SRST_IN = 1'h0;
        host_model_i.op(4'hC, 1'h0, 3'h4, r[3:0]);
        host_model_i.op(4'hC, 1'h0, 3'h5, r[7:4]);
        cmp(dce, r[7:0]);
        exp_q.push_back(r[3:0]);
        host_model_i.op(4'hA, 1'h0, 3'h4, 4'h0);
        exp_q.push_back(r[7:4]);
        host_model_i.op(4'hA, 1'h0, 3'h5, 4'h0);
        rdx(2'h3, 4'h0);
        @(negedge CLOCK_IN) ovl = 8'h21;
        @(negedge CLOCK_IN) ovl = 8'h00;
        cmp(on, 8'hDE);
        rdx(2'h0, 4'h1);
        @(negedge CLOCK_IN) ot = 8'h28;
        @(negedge CLOCK_IN) ot = 8'h00;
        cmp(on, 8'hD6);
        rdx(2'h1, 4'h4);
        rdx(2'h2, 4'h4);
        olc = 8'h22;
        repeat (12) @(negedge CLOCK_IN);
        olc = 8'h00;
        repeat (2) @(negedge CLOCK_IN);
        rdx(2'h2, 4'hC);
        rdx(2'h0, 4'h1);
        rdx(2'h2, 4'h4);
        ot = 8'h08;
        host_model_i.op(4'h9, 1'h0, 3'h6, 4'h1);
        cmp({7'h00, clear_protection_latch}, 8'h01);
        cmp(on, 8'hD7);
        rdx(2'h1, 4'h4);
        rdx(2'h0, 4'h0);
        cmp({7'h00, clear_protection_latch}, 8'h00);
        ot = 8'h00;
        repeat (3) @(negedge CLOCK_IN);
        test_done;
    end
endmodule // channel_fault_diagnosis_test
bind channel_fault_diagnosis chan_diag_chk chk_i(.*);

// ===== host_model.sv
// Purpose: Host side issuing one frame per operation.
// Assumes: Strobes change at the falling edge.  Notes: Released address and data lines invert.
`timescale 1ns/100ps
module host_model(input wire clock_in, output reg fr_out, output reg wr_out,
    output reg rd_out, output reg cl_out, output reg bk_out, output reg [2:0] ad_out,
    output reg [3:0] wd_out);
    initial {fr_out, wr_out, rd_out, cl_out, bk_out, ad_out, wd_out} = 12'h000;
    task op(input [3:0] k, input b, input [2:0] a, input [3:0] d);
        begin
            @(negedge clock_in) {fr_out, wr_out, rd_out, cl_out} <= k;
            {bk_out, ad_out, wd_out} <= {b, a, d};
            @(negedge clock_in) {fr_out, wr_out, rd_out, cl_out} <= 4'h0;
            {ad_out, wd_out} <= ~{a, d};
        end
    endtask
endmodule // host_model

// ===== open_load_timer.v
// Purpose: Per-channel persistence timer for the off-state open-load condition.
// Assumes: Condition input already synchronous to the clock.
// Notes:   Raises done once the condition has held for DELAY cycles while armed; done stays high until arm or condition drops.
`timescale 1ns/100ps
module open_load_timer #(
    parameter integer DELAY = 20000,
    parameter integer W     = 15
) (
    input  wire clk_in,
    input  wire srst_in,
    input  wire arm_in,
    input  wire cond_in,
    output reg  done_out
);
    reg [W-1:0] cnt_reg;
    always @(posedge clk_in) begin
        if (srst_in || !arm_in || !cond_in) begin
            cnt_reg  <= {W{1'h0}};
            done_out <= 1'h0;
        end else if (cnt_reg == DELAY[W-1:0] - 1'h1) begin
            done_out <= 1'h1;
        end else begin
            cnt_reg  <= cnt_reg + 1'h1;
            done_out <= 1'h0;
        end
    end
endmodule // open_load_timer
